// ===== rtl/scpc_regs.svh
// register offsets, field positions and reset values for sleep/clock control
`ifndef SCPC_REGS_SVH
`define SCPC_REGS_SVH
`define SCPC_SLEEP_ADDR 8'hbe
`define SCPC_CLOCK_SOURCE_CONTROL_ADDR 8'hc6
`define SCPC_POWER_CONTROL_REG_ADDR 8'h87
`define SCPC_SLP_CALDIS 7
`define SCPC_SLP_XSTB 6
`define SCPC_SLP_RSTB 5
`define SCPC_SLP_RST_LO 3
`define SCPC_SLP_PD 2
`define SCPC_SLP_MODE_LO 0
`define SCPC_CLK_SLOW 7
`define SCPC_CLK_SYS 6
`define SCPC_CLK_TICK_LO 3
`define SCPC_CLK_SPD 0
`define SCPC_POWER_CONTROL_REG_IDLE 0
`define SCPC_RST_CALDIS 1'h0
`define SCPC_RST_PD 1'h1
`define SCPC_RST_MODE 2'h0
`define SCPC_RST_SLOW 1'h1
`define SCPC_RST_SYS 1'h1
`define SCPC_RST_TICK 3'h1
`define SCPC_RST_SPD 1'h1
`define SCPC_CAUSE_POR 2'h0
`define SCPC_CAUSE_EXT 2'h1
`define SCPC_CAUSE_WDT 2'h2
`endif

// ===== rtl/scpc_pkg.sv
// types for the sleep and clock power control block
package scpc_pkg;
    typedef enum logic [1:0] {
        SCPC_PM0 = 2'h0,
        SCPC_PM1 = 2'h1,
        SCPC_PM2 = 2'h2,
        SCPC_PM3 = 2'h3
    } scpc_mode_e;
    typedef enum logic [1:0] {
        SCPC_RUN = 2'h0,
        SCPC_SLEEPING = 2'h1
    } scpc_state_e;
    typedef struct packed {
        scpc_state_e state;
        logic rc32k_cal_disable;
        logic cal_active;
        logic unused_osc_powerdown;
        logic pd_pending;
        logic pd_pending_val;
        scpc_mode_e mode;
        logic [1:0] reset_cause;
        logic slow_clock_select;
        logic sys_sel;
        logic sysclk_speed_flag;
        logic [2:0] timer_tick_rate;
        logic [2:0] xstb_sync;
        logic [2:0] rstb_sync;
        logic [2:0] calb_sync;
        logic xstb;
        logic rstb;
        logic calb;
        logic [7:0] rdata;
        logic hf_crystal_osc_pwr;
        logic rcosc_pwr;
        logic rc32k_cal_en;
        logic hf_rc_cal_en;
        logic sys_use_rc;
        logic slow_use_rc;
        logic sleep_req;
        logic [2:0] tick;
        logic cause_captured;
    } scpc_state_s;
endpackage

// ===== rtl/scpc_ctrl.sv
// sleep mode and clock source control with register access
`timescale 1ns/100ps
`default_nettype none
`include "scpc_regs.svh"
module scpc_ctrl (
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic power_on_reset_n,
    input wire logic brownout_reset_n,
    input wire logic ext_reset_n,
    input wire logic wdt_reset,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire logic [7:0] sfr_addr,
    input wire logic [7:0] sfr_wdata,
    input wire logic wake_event,
    input wire logic hf_crystal_ready,
    input wire logic hf_rc_ready,
    input wire logic cal_busy,
    output logic [7:0] sfr_rdata,
    output logic hf_crystal_osc_on,
    output logic rc_osc_a_on,
    output logic rc32k_cal_enable,
    output logic hf_rc_cal_enable,
    output logic sysclk_use_rc,
    output logic slowclk_use_rc,
    output logic sleep_request,
    output logic [1:0] sleep_mode,
    output logic [2:0] timer_tick_rate
);
    scpc_pkg::scpc_state_s s_reg;
    scpc_pkg::scpc_state_s s_next;
    logic rst_n;

    // arst_n, power-on and brownout resets each hold everything in reset; ext_reset_n does not
    assign rst_n = arst_n & power_on_reset_n & brownout_reset_n;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] ref_a);
        hit = (a == ref_a);
    endfunction

    always_comb begin
        logic wr_sleep;
        logic wr_clk;
        logic wr_power_control_reg;
        logic want_rc;
        logic rc_on;
        logic x_on;
        wr_sleep = 1'b0;
        wr_clk = 1'b0;
        wr_power_control_reg = 1'b0;
        want_rc = 1'b0;
        rc_on = 1'b0;
        x_on = 1'b0;
        s_next = s_reg;
        wr_sleep = sfr_wr && hit(sfr_addr, `SCPC_SLEEP_ADDR);
        wr_clk = sfr_wr && hit(sfr_addr, `SCPC_CLOCK_SOURCE_CONTROL_ADDR);
        wr_power_control_reg = sfr_wr && hit(sfr_addr, `SCPC_POWER_CONTROL_REG_ADDR);
        // three-stage synchronisers, change accepted when stages two and three agree
        s_next.xstb_sync = {s_reg.xstb_sync[1:0], hf_crystal_ready};
        s_next.rstb_sync = {s_reg.rstb_sync[1:0], hf_rc_ready};
        s_next.calb_sync = {s_reg.calb_sync[1:0], cal_busy};
        s_next.xstb = s_reg.xstb & s_reg.hf_crystal_osc_pwr;
        s_next.rstb = s_reg.rstb & s_reg.rcosc_pwr;
        if (s_reg.xstb_sync[1] == s_reg.xstb_sync[2]) begin
            s_next.xstb = s_reg.xstb_sync[2] & s_reg.hf_crystal_osc_pwr;
        end
        if (s_reg.rstb_sync[1] == s_reg.rstb_sync[2]) begin
            s_next.rstb = s_reg.rstb_sync[2] & s_reg.rcosc_pwr;
        end
        if (s_reg.calb_sync[1] == s_reg.calb_sync[2]) begin
            s_next.calb = s_reg.calb_sync[2];
        end
        s_next.cal_active = s_reg.calb & s_reg.rc32k_cal_en;
        // reset cause captured once after release
        if (!s_reg.cause_captured) begin
            s_next.cause_captured = 1'b1;
            if (wdt_reset) begin
                s_next.reset_cause = `SCPC_CAUSE_WDT;
            end else if (!ext_reset_n) begin
                s_next.reset_cause = `SCPC_CAUSE_EXT;
            end else begin
                s_next.reset_cause = `SCPC_CAUSE_POR;
            end
        end
        if (wr_sleep) begin
            s_next.rc32k_cal_disable = sfr_wdata[`SCPC_SLP_CALDIS];
            s_next.mode = scpc_pkg::scpc_mode_e'(sfr_wdata[`SCPC_SLP_MODE_LO +: 2]);
            if (s_reg.cal_active) begin
                s_next.pd_pending = 1'b1;
                s_next.pd_pending_val = sfr_wdata[`SCPC_SLP_PD];
            end else begin
                s_next.unused_osc_powerdown = sfr_wdata[`SCPC_SLP_PD];
                s_next.pd_pending = 1'b0;
            end
        end else if (s_reg.pd_pending && !s_reg.cal_active) begin
            s_next.pd_pending = 1'b0;
            s_next.unused_osc_powerdown = s_reg.pd_pending_val;
        end
        if (wr_clk) begin
            s_next.slow_clock_select = sfr_wdata[`SCPC_CLK_SLOW];
            s_next.sys_sel = sfr_wdata[`SCPC_CLK_SYS];
            s_next.timer_tick_rate = sfr_wdata[`SCPC_CLK_TICK_LO +: 3];
        end
        // oscillator power: selected and in-use ones are always on, other only if powerdown clear
        want_rc = s_reg.sys_sel;
        rc_on = want_rc || !s_reg.unused_osc_powerdown || s_reg.sys_use_rc;
        x_on = !want_rc || !s_reg.unused_osc_powerdown || !s_reg.sys_use_rc;
        s_next.rcosc_pwr = rc_on;
        s_next.hf_crystal_osc_pwr = x_on;
        // switch source only when the chosen one is stable
        if (want_rc != s_reg.sys_use_rc) begin
            if ((want_rc && s_reg.rstb) || (!want_rc && s_reg.xstb)) begin
                s_next.sys_use_rc = want_rc;
                s_next.sysclk_speed_flag = want_rc;
            end
        end
        s_next.slow_use_rc = s_reg.slow_clock_select;
        // calibration disable honoured only while running on the RC oscillator
        if (s_reg.rc32k_cal_disable && s_reg.sys_use_rc) begin
            s_next.rc32k_cal_en = 1'b0;
        end else if (!s_reg.rc32k_cal_disable) begin
            s_next.rc32k_cal_en = !s_reg.sys_use_rc && s_reg.xstb && s_reg.mode == scpc_pkg::SCPC_PM0;
        end
        s_next.hf_rc_cal_en = !s_reg.sys_use_rc && s_reg.rcosc_pwr && s_reg.rstb;
        s_next.tick = s_reg.timer_tick_rate;
        // sleep sequencing
        s_next.sleep_req = 1'b0;
        unique case (s_reg.state)
            scpc_pkg::SCPC_RUN: begin
                if (wr_power_control_reg && sfr_wdata[`SCPC_POWER_CONTROL_REG_IDLE] && s_reg.mode != scpc_pkg::SCPC_PM0
                    && !s_reg.cal_active) begin
                    s_next.state = scpc_pkg::SCPC_SLEEPING;
                    s_next.sleep_req = 1'b1;
                end
            end
            scpc_pkg::SCPC_SLEEPING: begin
                s_next.sleep_req = 1'b1;
                if (wake_event) begin
                    s_next.state = scpc_pkg::SCPC_RUN;
                    s_next.sleep_req = 1'b0;
                    s_next.mode = scpc_pkg::SCPC_PM0;
                    if (s_reg.mode == scpc_pkg::SCPC_PM2 || s_reg.mode == scpc_pkg::SCPC_PM3) begin
                        s_next.rc32k_cal_disable = `SCPC_RST_CALDIS;
                        s_next.slow_clock_select = `SCPC_RST_SLOW;
                    end
                end
            end
            default: begin
                s_next.state = scpc_pkg::SCPC_RUN;
            end
        endcase
        s_next.rdata = 8'h00;
        if (sfr_rd && hit(sfr_addr, `SCPC_SLEEP_ADDR)) begin
            s_next.rdata = {s_reg.rc32k_cal_disable, s_reg.xstb, s_reg.rstb, s_reg.reset_cause,
                            s_reg.unused_osc_powerdown, s_reg.mode};
        end else if (sfr_rd && hit(sfr_addr, `SCPC_CLOCK_SOURCE_CONTROL_ADDR)) begin
            s_next.rdata = {s_reg.slow_clock_select, s_reg.sys_sel, s_reg.timer_tick_rate, 2'h0,
                            s_reg.sysclk_speed_flag};
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            s_reg <= '0;
            s_reg.state <= scpc_pkg::SCPC_RUN;
            s_reg.rc32k_cal_disable <= `SCPC_RST_CALDIS;
            s_reg.unused_osc_powerdown <= `SCPC_RST_PD;
            s_reg.mode <= scpc_pkg::scpc_mode_e'(`SCPC_RST_MODE);
            s_reg.slow_clock_select <= `SCPC_RST_SLOW;
            s_reg.sys_sel <= `SCPC_RST_SYS;
            s_reg.sys_use_rc <= `SCPC_RST_SYS;
            s_reg.sysclk_speed_flag <= `SCPC_RST_SPD;
            s_reg.timer_tick_rate <= `SCPC_RST_TICK;
            s_reg.tick <= `SCPC_RST_TICK;
            s_reg.rcosc_pwr <= 1'b1;
            s_reg.slow_use_rc <= 1'b1;
        end else begin
            s_reg <= s_next;
        end
    end

    assign sfr_rdata = s_reg.rdata;
    assign hf_crystal_osc_on = s_reg.hf_crystal_osc_pwr;
    assign rc_osc_a_on = s_reg.rcosc_pwr;
    assign rc32k_cal_enable = s_reg.rc32k_cal_en;
    assign hf_rc_cal_enable = s_reg.hf_rc_cal_en;
    assign sysclk_use_rc = s_reg.sys_use_rc;
    assign slowclk_use_rc = s_reg.slow_use_rc;
    assign sleep_request = s_reg.sleep_req;
    assign sleep_mode = s_reg.mode;
    assign timer_tick_rate = s_reg.tick;

    property p_switch_needs_stable;
        @(posedge core_clk) disable iff (!rst_n)
        $changed(s_reg.sys_use_rc) |-> (s_reg.sys_use_rc ? $past(s_reg.rstb) : $past(s_reg.xstb));
    endproperty
    a_switch_needs_stable: assert property (p_switch_needs_stable) else $error("clock switched before stable");

    property p_speed_follows;
        @(posedge core_clk) disable iff (!rst_n)
        s_reg.sysclk_speed_flag == s_reg.sys_use_rc;
    endproperty
    a_speed_follows: assert property (p_speed_follows) else $error("speed flag mismatch");

    property p_selected_powered;
        @(posedge core_clk) disable iff (!rst_n)
        $past(s_reg.sys_sel) |-> rc_osc_a_on;
    endproperty
    a_selected_powered: assert property (p_selected_powered) else $error("selected rc not powered");

    property p_both_on;
        @(posedge core_clk) disable iff (!rst_n)
        !$past(s_reg.unused_osc_powerdown) |-> (rc_osc_a_on && hf_crystal_osc_on);
    endproperty
    a_both_on: assert property (p_both_on) else $error("oscillator off with powerdown clear");

    property p_pd_deferred;
        @(posedge core_clk) disable iff (!rst_n)
        s_reg.cal_active && !$past(s_reg.pd_pending) && s_reg.pd_pending |-> $stable(s_reg.unused_osc_powerdown);
    endproperty
    a_pd_deferred: assert property (p_pd_deferred) else $error("powerdown updated during calibration");

    property p_xstb_needs_power;
        @(posedge core_clk) disable iff (!rst_n)
        s_reg.xstb |-> $past(s_reg.hf_crystal_osc_pwr);
    endproperty
    a_xstb_needs_power: assert property (p_xstb_needs_power) else $error("crystal stable while off");

    property p_rstb_needs_power;
        @(posedge core_clk) disable iff (!rst_n)
        s_reg.rstb |-> $past(s_reg.rcosc_pwr);
    endproperty
    a_rstb_needs_power: assert property (p_rstb_needs_power) else $error("rc stable while off");

    property p_wake_pm0;
        @(posedge core_clk) disable iff (!rst_n)
        s_reg.state == scpc_pkg::SCPC_SLEEPING && wake_event |=> sleep_mode == 2'h0 && !sleep_request;
    endproperty
    a_wake_pm0: assert property (p_wake_pm0) else $error("wake did not return to mode 0");

    property p_deep_wake_restore;
        @(posedge core_clk) disable iff (!rst_n)
        s_reg.state == scpc_pkg::SCPC_SLEEPING && wake_event && s_reg.mode[1]
        |=> s_reg.slow_clock_select && !s_reg.rc32k_cal_disable;
    endproperty
    a_deep_wake_restore: assert property (p_deep_wake_restore) else $error("bits not restored");

    property p_caldis_rc;
        @(posedge core_clk) disable iff (!rst_n)
        s_reg.rc32k_cal_disable && s_reg.sys_use_rc |=> !rc32k_cal_enable;
    endproperty
    a_caldis_rc: assert property (p_caldis_rc) else $error("calibration not disabled");

    property p_tick_write;
        @(posedge core_clk) disable iff (!rst_n)
        sfr_wr && sfr_addr == `SCPC_CLOCK_SOURCE_CONTROL_ADDR
        |=> s_reg.timer_tick_rate == $past(sfr_wdata[`SCPC_CLK_TICK_LO +: 3]);
    endproperty
    a_tick_write: assert property (p_tick_write) else $error("tick field not written");

    property p_sys_sel_write;
        @(posedge core_clk) disable iff (!rst_n)
        sfr_wr && sfr_addr == `SCPC_CLOCK_SOURCE_CONTROL_ADDR |=> s_reg.sys_sel == $past(sfr_wdata[`SCPC_CLK_SYS]);
    endproperty
    a_sys_sel_write: assert property (p_sys_sel_write) else $error("clock select not written");

    property p_mode_write;
        @(posedge core_clk) disable iff (!rst_n)
        sfr_wr && sfr_addr == `SCPC_SLEEP_ADDR && s_reg.state == scpc_pkg::SCPC_RUN
        |=> sleep_mode == $past(sfr_wdata[`SCPC_SLP_MODE_LO +: 2]);
    endproperty
    a_mode_write: assert property (p_mode_write) else $error("mode field not written");

    property p_cause_stable;
        @(posedge core_clk) disable iff (!rst_n)
        s_reg.cause_captured |=> $stable(s_reg.reset_cause);
    endproperty
    a_cause_stable: assert property (p_cause_stable) else $error("reset cause changed");

    property p_cause_legal;
        @(posedge core_clk) disable iff (!rst_n)
        s_reg.reset_cause != 2'h3;
    endproperty
    a_cause_legal: assert property (p_cause_legal) else $error("reset cause code illegal");

    property p_sleep_needs_mode;
        @(posedge core_clk) disable iff (!rst_n)
        $rose(sleep_request) |-> $past(s_reg.mode) != scpc_pkg::SCPC_PM0;
    endproperty
    a_sleep_needs_mode: assert property (p_sleep_needs_mode) else $error("sleep entered in mode 0");

    property p_slow_follows;
        @(posedge core_clk) disable iff (!rst_n)
        slowclk_use_rc == $past(s_reg.slow_clock_select);
    endproperty
    a_slow_follows: assert property (p_slow_follows) else $error("slow clock source mismatch");

    property p_rc_unused_off;
        @(posedge core_clk) disable iff (!rst_n)
        $past(s_reg.unused_osc_powerdown) && !$past(s_reg.sys_sel) && !$past(s_reg.sys_use_rc)
        |-> !rc_osc_a_on;
    endproperty
    a_rc_unused_off: assert property (p_rc_unused_off) else $error("unused rc still powered");

    property p_speed_reads;
        @(posedge core_clk) disable iff (!rst_n)
        sfr_rd && sfr_addr == `SCPC_CLOCK_SOURCE_CONTROL_ADDR
        |=> sfr_rdata[`SCPC_CLK_SPD] == $past(s_reg.sysclk_speed_flag);
    endproperty
    a_speed_reads: assert property (p_speed_reads) else $error("speed flag read wrong");

    property p_stable_reads;
        @(posedge core_clk) disable iff (!rst_n)
        sfr_rd && sfr_addr == `SCPC_SLEEP_ADDR
        |=> sfr_rdata[`SCPC_SLP_XSTB] == $past(s_reg.xstb) && sfr_rdata[`SCPC_SLP_RSTB] == $past(s_reg.rstb);
    endproperty
    a_stable_reads: assert property (p_stable_reads) else $error("stable flags read wrong");

    c_switch_to_hf_crystal_osc: cover property (@(posedge core_clk) disable iff (!rst_n) $fell(s_reg.sys_use_rc));
    c_sleep_wake: cover property (@(posedge core_clk) disable iff (!rst_n) $fell(sleep_request));
    c_pd_deferred: cover property (@(posedge core_clk) disable iff (!rst_n) $fell(s_reg.pd_pending));
    c_deep_wake: cover property (@(posedge core_clk) disable iff (!rst_n)
        s_reg.state == scpc_pkg::SCPC_SLEEPING && wake_event && s_reg.mode[1]);
    c_cal_stop: cover property (@(posedge core_clk) disable iff (!rst_n) $fell(rc32k_cal_enable));
endmodule
`default_nettype wire

// ===== sim/test_sleep_clock_power_control.sv
// self-checking bench for the sleep and clock power control block
`timescale 1ns/100ps
`default_nettype none
module test_sleep_clock_power_control;
    logic core_clk, arst_n, power_on_reset_n, brownout_reset_n, ext_reset_n, wdt_reset;
    logic sfr_wr, sfr_rd, wake_event, hf_crystal_ready, hf_rc_ready, cal_busy;
    logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, rd_val;
    logic hf_crystal_osc_on, rc_osc_a_on, rc32k_cal_enable, hf_rc_cal_enable;
    logic sysclk_use_rc, slowclk_use_rc, sleep_request;
    logic [1:0] sleep_mode;
    logic [2:0] timer_tick_rate;
    int err_count = 0;
    int check_count = 0;
    logic [7:0] row_addr [0:10];
    logic [7:0] row_wdata [0:10];
    logic [7:0] row_rexp [0:10];

    scpc_ctrl DUT (.core_clk(core_clk), .arst_n(arst_n), .power_on_reset_n(power_on_reset_n),
        .brownout_reset_n(brownout_reset_n), .ext_reset_n(ext_reset_n), .wdt_reset(wdt_reset),
        .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata),
        .wake_event(wake_event), .hf_crystal_ready(hf_crystal_ready), .hf_rc_ready(hf_rc_ready),
        .cal_busy(cal_busy), .sfr_rdata(sfr_rdata), .hf_crystal_osc_on(hf_crystal_osc_on),
        .rc_osc_a_on(rc_osc_a_on), .rc32k_cal_enable(rc32k_cal_enable), .hf_rc_cal_enable(hf_rc_cal_enable),
        .sysclk_use_rc(sysclk_use_rc), .slowclk_use_rc(slowclk_use_rc), .sleep_request(sleep_request),
        .sleep_mode(sleep_mode), .timer_tick_rate(timer_tick_rate));

    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end

    task end_of_test;
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_count++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        sfr_wr <= 1'b1;
        sfr_addr <= a;
        sfr_wdata <= d;
        @(posedge core_clk);
        sfr_wr <= 1'b0;
    endtask

    task rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge core_clk);
        sfr_rd <= 1'b1;
        sfr_addr <= a;
        @(posedge core_clk);
        sfr_rd <= 1'b0;
        #1;
        d = sfr_rdata;
    endtask

    task automatic wait_on(input string nm, ref logic s, input logic v);
        int n;
        n = 0;
        while (s !== v && n < 64) begin
            @(posedge core_clk);
            #1;
            n++;
        end
        check_count++;
        if (s !== v) begin
            err_count++;
            $display("wrong value %s expected %h seen %h", nm, v, s);
            end_of_test();
        end
    endtask

    task settle(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask

    initial begin
        logic [7:0] rexp;
        logic ext_n [0:2];
        logic wdt [0:2];
        logic bo [0:2];
        logic [1:0] cause [0:2];
        ext_n = '{1'b0, 1'b1, 1'b1};
        wdt = '{1'b0, 1'b1, 1'b0};
        bo = '{1'b0, 1'b0, 1'b1};
        cause = '{2'h1, 2'h2, 2'h0};
        arst_n = 1'b0;
        power_on_reset_n = 1'b1;
        brownout_reset_n = 1'b1;
        ext_reset_n = 1'b1;
        wdt_reset = 1'b0;
        sfr_wr = 1'b0;
        sfr_rd = 1'b0;
        sfr_addr = 8'h00;
        sfr_wdata = 8'h00;
        wake_event = 1'b0;
        hf_crystal_ready = 1'b0;
        hf_rc_ready = 1'b0;
        cal_busy = 1'b0;
        repeat (12) @(posedge core_clk);
        arst_n <= 1'b1;
        rd(8'hbe, rd_val);
        chk("sleep reset", rd_val, 8'h04);
        rd(8'hc6, rd_val);
        chk("clock reset", rd_val, 8'hc9);
        $display("reset values done");
        // table: ticks 1..7 on the rc clock, then sleep register and an unmapped place
        for (int k = 1; k < 8; k++) begin
            row_addr[k-1] = 8'hc6;
            row_wdata[k-1] = 8'hc0 | 8'(k << 3);
            row_rexp[k-1] = 8'hc1 | 8'(k << 3);
        end
        row_addr[7:10] = '{8'hbe, 8'hbe, 8'hbe, 8'h55};
        row_wdata[7:10] = '{8'h7d, 8'h81, 8'h04, 8'hff};
        row_rexp[7:10] = '{8'h05, 8'h81, 8'h04, 8'h00};
        for (int i = 0; i < 11; i++) begin
            wr(row_addr[i], row_wdata[i]);
            rd(row_addr[i], rd_val);
            chk("table read", rd_val, row_rexp[i]);
            if (row_addr[i] == 8'hc6) chk("tick out", 8'(timer_tick_rate), 8'(row_wdata[i][5:3]));
        end
        $display("register table done");
        hf_rc_ready <= 1'b1;
        wr(8'hc6, 8'h88);
        wait_on("crystal power", hf_crystal_osc_on, 1'b1);
        settle(8);
        chk("old source kept", 8'(sysclk_use_rc), 8'h01);
        rd(8'hc6, rd_val);
        chk("speed before stable", rd_val, 8'h89);
        hf_crystal_ready <= 1'b1;
        wait_on("switch to crystal", sysclk_use_rc, 1'b0);
        settle(6);
        rd(8'hc6, rd_val);
        chk("speed after stable", rd_val, 8'h88);
        chk("rc powered down", 8'(rc_osc_a_on), 8'h00);
        chk("hf rc calibration off", 8'(hf_rc_cal_enable), 8'h00);
        rd(8'hbe, rd_val);
        chk("crystal stable flag", rd_val, 8'h44);
        chk("rc32k calibration", 8'(rc32k_cal_enable), 8'h01);
        $display("clock switch done");
        cal_busy <= 1'b1;
        settle(5);
        wr(8'hbe, 8'h00);
        settle(4);
        chk("deferred powerdown", 8'(rc_osc_a_on), 8'h00);
        rd(8'hbe, rd_val);
        chk("deferred bit", rd_val & 8'h04, 8'h04);
        cal_busy <= 1'b0;
        wait_on("powerdown applied", rc_osc_a_on, 1'b1);
        $display("deferred powerdown done");
        wr(8'hc6, 8'h80);
        rd(8'hc6, rd_val);
        chk("tick 32 MHz", rd_val, 8'h80);
        wr(8'hbe, 8'h80);
        settle(6);
        chk("disable not yet", 8'(rc32k_cal_enable), 8'h01);
        rd(8'hbe, rd_val);
        chk("both stable", rd_val, 8'he0);
        chk("hf rc calibration on", 8'(hf_rc_cal_enable), 8'h01);
        wr(8'hc6, 8'hc8);
        wait_on("back to rc", sysclk_use_rc, 1'b1);
        settle(4);
        chk("calibration off", 8'(rc32k_cal_enable), 8'h00);
        $display("calibration disable done");
        wr(8'h87, 8'h01);
        settle(4);
        chk("idle in mode 0", 8'(sleep_request), 8'h00);
        wr(8'hc6, 8'h48);
        wait_on("slow crystal", slowclk_use_rc, 1'b0);
        wr(8'hbe, 8'h82);
        wr(8'h87, 8'h01);
        wait_on("sleep entry", sleep_request, 1'b1);
        chk("mode out", 8'(sleep_mode), 8'h02);
        wake_event <= 1'b1;
        wait_on("wake", sleep_request, 1'b0);
        wake_event <= 1'b0;
        settle(2);
        chk("mode cleared", 8'(sleep_mode), 8'h00);
        chk("slow rc again", 8'(slowclk_use_rc), 8'h01);
        rd(8'hbe, rd_val);
        chk("caldis and mode", rd_val & 8'h83, 8'h00);
        rd(8'hc6, rd_val);
        chk("slow select", rd_val & 8'h80, 8'h80);
        $display("sleep and wake done");
        for (int i = 0; i < 3; i++) begin
            wr(8'hbe, 8'h80);
            wr(8'hc6, 8'hd0);
            @(posedge core_clk);
            ext_reset_n <= ext_n[i];
            wdt_reset <= wdt[i];
            if (bo[i]) brownout_reset_n <= 1'b0;
            else arst_n <= 1'b0;
            settle(3);
            chk("tick in reset", 8'(timer_tick_rate), 8'h01);
            chk("rc in reset", 8'(sysclk_use_rc), 8'h01);
            chk("crystal in reset", 8'(hf_crystal_osc_on), 8'h00);
            arst_n <= 1'b1;
            brownout_reset_n <= 1'b1;
            settle(2);
            ext_reset_n <= 1'b1;
            wdt_reset <= 1'b0;
            rd(8'hbe, rd_val);
            rexp = 8'(cause[i]) << 3;
            chk("reset cause", rd_val & 8'h18, rexp);
        end
        $display("reset cause done");
        end_of_test();
    end
endmodule
`default_nettype wire
